// *** include/dcd_pkg.sv ***
/*
  Shared constants, field layouts and carriers of the dual channel converter control block.
  Assumes one 100 MHz clock and a byte-wide register port with a 5-bit address.
*/
package dcd_pkg;

  // Register addresses on the byte-wide register port.
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_CONTROL_A = 5'h00;
  localparam logic [4:0] ADDR_CONTROL_B = 5'h01;
  localparam logic [4:0] ADDR_CONTROL_C = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_TIMING_CONTROL = 5'h04;
  localparam logic [4:0] ADDR_GAIN_TRIM = 5'h08;
  localparam logic [4:0] ADDR_OFFSET_TRIM = 5'h09;
  localparam logic [4:0] ADDR_CHAN0_LO = 5'h10;
  localparam logic [4:0] ADDR_CHAN0_HI = 5'h11;
  localparam logic [4:0] ADDR_CHAN1_LO = 5'h12;
  localparam logic [4:0] ADDR_CHAN1_HI = 5'h13;

  // Field positions inside control_a, control_b, control_c and timing_control.
  localparam int ENABLE_BIT = 0;
  localparam int CHAN0_OUT_BIT = 2;
  localparam int CHAN1_OUT_BIT = 3;
  localparam int CHAN0_TRIG_BIT = 0;
  localparam int CHAN1_TRIG_BIT = 1;
  localparam int MODE_LSB = 5;
  localparam int LEFT_ALIGN_BIT = 0;
  localparam int REF_LSB = 3;
  localparam int SEP_LSB = 4;
  localparam int REFRESH_LSB = 0;

  // Writable bits of the control and timing registers; all others read as zero.
  localparam logic [7:0] CONTROL_A_MASK = 8'h0D;
  localparam logic [7:0] CONTROL_B_MASK = 8'h63;
  localparam logic [7:0] CONTROL_C_MASK = 8'h19;
  localparam logic [7:0] TIMING_MASK = 8'h7F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] TRIM_RESET = 7'h00;

  // Encodings of the mode and reference fields.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h2;
  localparam logic [1:0] REF_BANDGAP = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_EXTERNAL = 2'h2;

  // Interval timer widths and the gain correction scale.
  localparam int SEP_TIMER_W = 8;
  localparam int REFRESH_TIMER_W = 17;
  localparam int GAIN_SHIFT = 10;

  // One conversion handed to the converter: code and target channel.
  typedef struct packed {
    logic [11:0] code;
    logic chan;
  } dcd_conv_s;

  // Sample interval in clock cycles: two to the power of the field.
  function automatic logic [SEP_TIMER_W-1:0] dcd_sep_cycles(input logic [2:0] field);
    dcd_sep_cycles = SEP_TIMER_W'(1) << field;
  endfunction : dcd_sep_cycles

  // Refresh interval in clock cycles: two to the power of field plus one; zero turns refresh off.
  function automatic logic [REFRESH_TIMER_W-1:0] dcd_refresh_cycles(input logic [3:0] field);
    dcd_refresh_cycles = REFRESH_TIMER_W'(2) << field;
  endfunction : dcd_refresh_cycles

endpackage : dcd_pkg

// *** design/dcd_interval_timer.sv ***
/*
  Programmable interval timer that emits a one-cycle tick every period cycles.
  Assumes period_in holds steady between restarts and is at least one.
*/
`timescale 1ns/1ps
module dcd_interval_timer #(
  parameter int WIDTH = 17
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic [WIDTH-1:0] period_in,
  output logic tick_out
);

  logic [WIDTH-1:0] count_r;

  // A one-bit counter cannot tell a reload apart from the tick value, so such widths are refused.
  if (WIDTH < 2) begin : g_width_check
    $error("dcd_interval_timer needs WIDTH of two or more");
  end

  // The count reloads on restart or after a tick, so a tick lands exactly period cycles after the load.
  always_ff @(posedge clock_in) begin
    if (srst_in || !run_in) begin
      count_r <= '0;
    end else if (restart_in || count_r <= WIDTH'(1)) begin
      count_r <= period_in;
    end else begin
      count_r <= count_r - WIDTH'(1);
    end
  end

  // The tick depends on the count and run_in only, never on restart_in, because callers build their restart from it.
  assign tick_out = run_in && (count_r == WIDTH'(1));

endmodule : dcd_interval_timer

// *** design/dcd_trim_apply.sv ***
/*
  Applies the offset and gain trim to each code on its way to the converter, with one register stage.
  Assumes trim values are sign-magnitude: bit 6 direction, bits 5..0 amount.
*/
`timescale 1ns/1ps
module dcd_trim_apply
  import dcd_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic go_in,
  input wire dcd_conv_s conv_in,
  input wire logic [6:0] gain_trim_in,
  input wire logic [6:0] offset_trim_in,
  output logic valid_out,
  output dcd_conv_s conv_out
);

  logic signed [14:0] gain_corr;
  logic signed [14:0] offset_corr;
  logic signed [14:0] sum;
  logic [11:0] clamped;
  logic [17:0] product;

  // Gain scales with the code itself; offset is a flat shift. Both share one path for every channel.
  assign product = conv_in.code * gain_trim_in[5:0];
  assign gain_corr = gain_trim_in[6] ? -$signed({7'h00, product[GAIN_SHIFT +: 8]})
                                      : $signed({7'h00, product[GAIN_SHIFT +: 8]});
  assign offset_corr = offset_trim_in[6] ? -$signed({9'h000, offset_trim_in[5:0]})
                                          : $signed({9'h000, offset_trim_in[5:0]});
  assign sum = $signed({3'h0, conv_in.code}) + gain_corr + offset_corr;
  assign clamped = sum < 0 ? 12'h000 : (sum > 15'sd4095 ? 12'hFFF : sum[11:0]);

  // Result is registered so the converter sees a stable code.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      valid_out <= 1'b0;
      conv_out <= '0;
    end else begin
      valid_out <= go_in;
      conv_out <= go_in ? dcd_conv_s'{code: clamped, chan: conv_in.chan} : conv_out;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  trim_neutral_a: assert property (go_in && gain_trim_in[5:0] == 6'h00 && offset_trim_in[5:0] == 6'h00
    |=> valid_out && conv_out.code == $past(conv_in.code))
    else $error("zero trim altered the code");

  trim_offset_a: assert property (go_in && gain_trim_in[5:0] == 6'h00 && !offset_trim_in[6]
    && conv_in.code == 12'h800 |=> conv_out.code == 12'h800 + {6'h00, $past(offset_trim_in[5:0])})
    else $error("positive offset trim not applied");

endmodule : dcd_trim_apply

// *** design/dcd_ctrl.sv ***
/*
  Control logic of a 12-bit converter with one conversion block shared by two channels.
  Holds the registers, trigger handling, refresh and sample interval scheduling, and the trim path.
  Assumes a byte-wide register port with read data one cycle after the read strobe, and event
  inputs that are one-cycle pulses synchronous to clock_in.
*/
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dcd_ctrl
  import dcd_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [1:0] event_in,
  output logic [1:0] ref_select_out,
  output logic drive0_en_out,
  output logic drive1_en_out,
  output logic dual_mode_out,
  output logic conv_valid_out,
  output dcd_conv_s conv_out
);

  // There is no interrupt output: register writes, events and the refresh timer drive all activity.
  // Software has to poll the status register when it needs to know that work is done.
  typedef enum logic [1:0] {S_IDLE, S_GAP, S_REF0, S_REF1} dcd_state_e;

  logic [7:0] control_a_r;
  logic [7:0] control_b_r;
  logic [7:0] control_c_r;
  logic [7:0] timing_r;
  logic [6:0] gain_trim_r;
  logic [6:0] offset_trim_r;
  logic [7:0] low_hold_r [2];
  logic [15:0] value_r [2];
  logic [7:0] rdata_sel;
  logic [1:0] pend_r;
  logic [1:0] pend_nxt;
  logic refresh_due_r;
  logic refresh_due_nxt;
  dcd_state_e state_r;
  dcd_state_e state_nxt;
  logic drive0_r;
  logic drive1_r;
  logic [1:0] ref_r;

  // Register writes and decoded fields.
  wire enable = control_a_r[ENABLE_BIT];
  wire [1:0] mode_field = control_b_r[MODE_LSB +: 2];
  wire dual = enable && (mode_field == MODE_DUAL);
  wire [1:0] trig_en = {control_b_r[CHAN1_TRIG_BIT], control_b_r[CHAN0_TRIG_BIT]};
  wire left_align = control_c_r[LEFT_ALIGN_BIT];
  wire [2:0] sep_field = timing_r[SEP_LSB +: 3];
  wire [3:0] refresh_field = timing_r[REFRESH_LSB +: 4];
  wire wr_timing = wr_in && addr_in == ADDR_TIMING_CONTROL;
  wire [1:0] wr_low = {wr_in && addr_in == ADDR_CHAN1_LO, wr_in && addr_in == ADDR_CHAN0_LO};
  wire [1:0] wr_high = {wr_in && addr_in == ADDR_CHAN1_HI, wr_in && addr_in == ADDR_CHAN0_HI};

  // Committed value of each channel as the converter takes it, right or left aligned.
  function automatic logic [11:0] dcd_pick(input logic [15:0] pair, input logic left);
    dcd_pick = left ? pair[15:4] : pair[11:0];
  endfunction : dcd_pick

  // Software-written configuration; writes outside the masks are dropped.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      control_a_r <= REG_RESET;
      control_b_r <= REG_RESET;
      control_c_r <= REG_RESET;
      timing_r <= REG_RESET;
      gain_trim_r <= TRIM_RESET;
      offset_trim_r <= TRIM_RESET;
    end else if (wr_in) begin
      case (addr_in)
        ADDR_CONTROL_A: control_a_r <= wdata_in & CONTROL_A_MASK;
        ADDR_CONTROL_B: control_b_r <= wdata_in & CONTROL_B_MASK;
        ADDR_CONTROL_C: control_c_r <= wdata_in & CONTROL_C_MASK;
        ADDR_TIMING_CONTROL: timing_r <= wdata_in & TIMING_MASK;
        ADDR_GAIN_TRIM: gain_trim_r <= wdata_in[6:0];
        ADDR_OFFSET_TRIM: offset_trim_r <= wdata_in[6:0];
        default: ;
      endcase
    end
  end

  // The low byte waits in a holding register and only joins the value on the high byte write,
  // so the converter never sees half of an update.
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < 2; i++) begin
      if (srst_in) begin
        low_hold_r[i] <= 8'h00;
        value_r[i] <= 16'h0000;
      end else if (wr_low[i]) begin
        low_hold_r[i] <= wdata_in;
      end else if (wr_high[i]) begin
        value_r[i] <= {wdata_in, low_hold_r[i]};
      end
    end
  end

  // Read mux; status shows pending requests, refresh state and scheduler activity.
  wire [7:0] status_word = {4'h0, state_r != S_IDLE, refresh_due_r, pend_r};
  always_comb begin
    case (addr_in)
      ADDR_CONTROL_A: rdata_sel = control_a_r;
      ADDR_CONTROL_B: rdata_sel = control_b_r;
      ADDR_CONTROL_C: rdata_sel = control_c_r;
      ADDR_STATUS: rdata_sel = status_word;
      ADDR_TIMING_CONTROL: rdata_sel = timing_r;
      ADDR_GAIN_TRIM: rdata_sel = {1'b0, gain_trim_r};
      ADDR_OFFSET_TRIM: rdata_sel = {1'b0, offset_trim_r};
      ADDR_CHAN0_LO: rdata_sel = low_hold_r[0];
      ADDR_CHAN0_HI: rdata_sel = value_r[0][15:8];
      ADDR_CHAN1_LO: rdata_sel = low_hold_r[1];
      ADDR_CHAN1_HI: rdata_sel = value_r[1][15:8];
      default: rdata_sel = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rd_in ? rdata_sel : 8'h00;
    end
  end

  // Trigger sources: a high byte write when events are off, an event pulse when they are on.
  // Channel 1 has no path in single mode because the converter is tied to channel 0 there.
  wire [1:0] chan_allowed = {dual, enable};
  wire [1:0] write_trig = wr_high & ~trig_en;
  wire [1:0] event_trig = event_in & trig_en;
  wire [1:0] trig = (write_trig | event_trig) & chan_allowed;

  // Interval timers: one paces the sample interval, one free-runs for refresh.
  wire sep_tick;
  wire refresh_tick;
  wire conv_go;
  wire refresh_on = dual && refresh_field != 4'h0;

  dcd_interval_timer #(
    .WIDTH(SEP_TIMER_W)
  ) u_sep_timer (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .run_in(dual),
    .restart_in(conv_go),
    .period_in(dcd_sep_cycles(sep_field)),
    .tick_out(sep_tick)
  );

  // Manual conversions do not restart the refresh timer, so refresh stays evenly spaced.
  dcd_interval_timer #(
    .WIDTH(REFRESH_TIMER_W)
  ) u_refresh_timer (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .run_in(refresh_on),
    .restart_in(wr_timing),
    .period_in(dcd_refresh_cycles(refresh_field)),
    .tick_out(refresh_tick)
  );

  // Scheduler: free when idle or when the sample interval has just run out.
  wire sched = state_r == S_IDLE || ((state_r == S_GAP || state_r == S_REF1) && sep_tick);
  wire ref_second = state_r == S_REF0 && sep_tick;
  wire start_refresh = dual && sched && refresh_due_r;
  wire serve0 = enable && sched && !start_refresh && pend_r[0];
  wire serve1 = dual && sched && !start_refresh && !pend_r[0] && pend_r[1];
  wire go_chan = ref_second || serve1;
  assign conv_go = start_refresh || ref_second || serve0 || serve1;

  // A request that lands while its flag is cleared survives, so no trigger is lost.
  // A second request for an already pending channel merges into the flag and is dropped.
  always_comb begin
    pend_nxt = (pend_r & ~{serve1, serve0}) | trig;
    refresh_due_nxt = (refresh_due_r && !start_refresh) || refresh_tick;
    if (!enable) begin
      pend_nxt = 2'b00;
      refresh_due_nxt = 1'b0;
    end
  end

  // State walk: a refresh converts channel 0, waits one sample interval, then channel 1.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE, S_GAP, S_REF1: begin
        if (sched) begin
          if (start_refresh) begin
            state_nxt = S_REF0;
          end else if (dual && (serve0 || serve1)) begin
            state_nxt = S_GAP;
          end else begin
            state_nxt = S_IDLE;
          end
        end
      end
      S_REF0: begin
        if (sep_tick) begin
          state_nxt = S_REF1;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    if (!dual) begin
      state_nxt = S_IDLE;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_r <= S_IDLE;
      pend_r <= 2'b00;
      refresh_due_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      refresh_due_r <= refresh_due_nxt;
    end
  end

  // Output drivers and reference selection follow the registers with one flop of delay.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      drive0_r <= 1'b0;
      drive1_r <= 1'b0;
      ref_r <= REF_BANDGAP;
    end else begin
      drive0_r <= enable && control_a_r[CHAN0_OUT_BIT];
      drive1_r <= dual && control_a_r[CHAN1_OUT_BIT];
      ref_r <= control_c_r[REF_LSB +: 2];
    end
  end

  assign drive0_en_out = drive0_r;
  assign drive1_en_out = drive1_r;
  assign ref_select_out = ref_r;
  assign dual_mode_out = dual;

  // The code handed over is always the committed pair, never the low holding byte.
  wire [11:0] pick_code = dcd_pick(value_r[go_chan], left_align);
  wire dcd_conv_s conv_req = '{code: pick_code, chan: go_chan};

  // Both modes use this one trim path, so calibration holds for either.
  dcd_trim_apply u_trim (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .go_in(conv_go),
    .conv_in(conv_req),
    .gain_trim_in(gain_trim_r),
    .offset_trim_in(offset_trim_r),
    .valid_out(conv_valid_out),
    .conv_out(conv_out)
  );

  // Helper counters for the timing checks below.
  logic [7:0] since_conv_r;
  logic [16:0] since_refresh_r;
  logic refresh_seen_r;
  always_ff @(posedge clock_in) begin
    if (srst_in || conv_go) begin
      since_conv_r <= 8'h01;
    end else if (since_conv_r != 8'hFF) begin
      since_conv_r <= since_conv_r + 8'h01;
    end
  end
  always_ff @(posedge clock_in) begin
    if (srst_in || refresh_tick || wr_timing) begin
      since_refresh_r <= 17'h0_0001;
      refresh_seen_r <= !srst_in && refresh_tick;
    end else begin
      since_refresh_r <= since_refresh_r + 17'h0_0001;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  conv_needs_enable_a: assert property (conv_valid_out |-> $past(enable))
    else $error("conversion while module disabled");

  high_write_starts_a: assert property (wr_high[0] && enable && !trig_en[0] |=> pend_r[0] || $past(pend_r[0]))
    else $error("high byte write did not request a conversion");

  low_write_quiet_a: assert property (wr_low[0] && !pend_r[0] && !event_in[0] |=> !pend_r[0])
    else $error("low byte write requested a conversion");

  event_mode_write_a: assert property (wr_high[1] && trig_en[1] && !pend_r[1] && !event_in[1] |=> !pend_r[1])
    else $error("data write converted in event mode");

  outputs_follow_a: assert property (!dual && !$past(dual) |-> !drive1_en_out)
    else $error("channel 1 driven outside dual mode");

  sample_gap_a: assert property (conv_go && dual && $past(dual) && sep_field == 3'h4
    && $stable(sep_field) |-> since_conv_r >= 8'd16)
    else $error("sample interval shorter than sixteen cycles");

  refresh_period_a: assert property (refresh_tick && refresh_seen_r && refresh_field == 4'h6
    |-> since_refresh_r == 17'd128)
    else $error("refresh interval not 128 cycles");

  refresh_both_a: assert property (start_refresh && $stable(timing_r) |-> ##[1:140] (conv_go && go_chan))
    else $error("refresh did not reach channel 1");

  refresh_blocks_a: assert property (state_r == S_REF0 |-> !(serve0 || serve1))
    else $error("request served inside a refresh");

  refresh_holds_a: assert property (state_r == S_REF0 && pend_r[0] && enable |=> pend_r[0])
    else $error("request dropped inside a refresh");

  single_chan0_a: assert property (conv_go && !dual |-> !go_chan)
    else $error("channel 1 converted in single mode");

  low_byte_held_a: assert property (wr_low[0] |=> $stable(value_r[0]))
    else $error("low byte write changed the committed value");

endmodule : dcd_ctrl

// *** verif/tb_top.sv ***
/*
  Self-checking bench for dcd_ctrl: register port tasks, a log of conversions and one scenario sequence.
  Assumes the dcd_pkg package is compiled first and a single 100 MHz clock with synchronous reset.
*/
`timescale 1ns/1ps
module tb_top
  import dcd_pkg::*;
();
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = 5'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [1:0] event_in = 2'h0;
  logic [7:0] rdata_out;
  logic [1:0] ref_select_out;
  logic drive0_en_out;
  logic drive1_en_out;
  logic dual_mode_out;
  logic conv_valid_out;
  dcd_conv_s conv_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [11:0] q_code[$];
  logic q_chan[$];
  int q_stamp[$];
  logic [4:0] reset_addrs[10] = '{ADDR_CONTROL_A, ADDR_CONTROL_B, ADDR_CONTROL_C, ADDR_STATUS, ADDR_TIMING_CONTROL,
    ADDR_GAIN_TRIM, ADDR_OFFSET_TRIM, ADDR_CHAN0_LO, ADDR_CHAN0_HI, 5'h1F};

  dcd_ctrl dcd_ctrl_i (.clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .event_in(event_in), .ref_select_out(ref_select_out),
    .drive0_en_out(drive0_en_out), .drive1_en_out(drive1_en_out), .dual_mode_out(dual_mode_out),
    .conv_valid_out(conv_valid_out), .conv_out(conv_out));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clock_in = ~clock_in;
  end

  // Logs every conversion with its cycle stamp, so intervals are measured without racing the stimulus.
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (conv_valid_out === 1'b1) begin
      q_code.push_back(conv_out.code);
      q_chan.push_back(conv_out.chan);
      q_stamp.push_back(cyc);
    end
  end

  // Prints the verdict and ends the run; every path out of the bench comes here.
  task automatic final_report;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Compares one observed value with its expected value.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One-cycle write strobe; the low edge after it keeps back-to-back calls from colliding.
  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    chk("register read", {8'h00, exp}, {8'h00, rdata_out});
  endtask : chk_rd

  // Lets registered level outputs land before they are looked at.
  task automatic settle;
    repeat (2) @(posedge clock_in);
    #1;
  endtask : settle

  // Empties the conversion log off the clock edge.
  task automatic clr;
    #1;
    q_code.delete();
    q_chan.delete();
    q_stamp.delete();
  endtask : clr

  // Waits, bounded, for n conversions, then checks that no extra one follows within the settle time.
  task automatic expect_convs(input int n, input int bound, input int quiet);
    for (int i = 0; i < bound && q_code.size() < n; i++) @(posedge clock_in);
    if (q_code.size() < n) begin
      n_mismatch++;
      $display("[FAIL] conversion count expected %0d seen %0d", n, q_code.size());
      final_report();
    end else begin
      repeat (quiet) @(posedge clock_in);
      #1;
      chk("conversion count", 16'(n), 16'(q_code.size()));
    end
  endtask : expect_convs

  task automatic chk_conv(input int idx, input logic [11:0] code, input logic chan);
    chk("conversion code", {4'h0, code}, {4'h0, q_code[idx]});
    chk("conversion channel", {15'h0000, chan}, {15'h0000, q_chan[idx]});
  endtask : chk_conv

  // Main sequence: reset values, reference, enable gating, triggers, trim, dual mode and refresh.
  initial begin
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    foreach (reset_addrs[i]) chk_rd(reset_addrs[i], 8'h00);
    for (int r = 0; r < 3; r++) begin
      reg_wr(ADDR_CONTROL_C, 8'(r << REF_LSB));
      settle();
      chk("reference select", 16'(r), {14'h0000, ref_select_out});
    end
    // Output bit set but module disabled: nothing may drive or convert.
    reg_wr(ADDR_CONTROL_A, 8'h04);
    settle();
    chk("output 0 enable", 16'h0000, {15'h0000, drive0_en_out});
    clr();
    reg_wr(ADDR_CHAN0_LO, 8'h23);
    reg_wr(ADDR_CHAN0_HI, 8'h01);
    expect_convs(0, 1, 24);
    reg_wr(ADDR_CONTROL_A, 8'h05);
    settle();
    chk("output 0 enable", 16'h0001, {15'h0000, drive0_en_out});
    chk("output 1 enable", 16'h0000, {15'h0000, drive1_en_out});
    chk("dual mode", 16'h0000, {15'h0000, dual_mode_out});
    // A low byte alone must not convert; the high byte commits the pair.
    clr();
    reg_wr(ADDR_CHAN0_LO, 8'h56);
    expect_convs(0, 1, 12);
    reg_wr(ADDR_CHAN0_HI, 8'h04);
    expect_convs(1, 8, 8);
    chk_conv(0, 12'h456, 1'b0);
    // Trims hold seven bits; a positive offset (direction bit clear) is added to the code.
    reg_wr(ADDR_GAIN_TRIM, 8'hFF);
    chk_rd(ADDR_GAIN_TRIM, 8'h7F);
    reg_wr(ADDR_GAIN_TRIM, 8'h00);
    reg_wr(ADDR_OFFSET_TRIM, 8'h05);
    chk_rd(ADDR_OFFSET_TRIM, 8'h05);
    reg_wr(ADDR_CONTROL_C, 8'h09);
    clr();
    reg_wr(ADDR_CHAN0_LO, 8'hC0);
    reg_wr(ADDR_CHAN0_HI, 8'hAB);
    expect_convs(1, 8, 8);
    chk_conv(0, 12'hAC1, 1'b0);
    reg_wr(ADDR_CONTROL_C, 8'h08);
    // Event trigger: writes stay silent, the event converts what the registers hold.
    reg_wr(ADDR_CONTROL_B, 8'h01);
    clr();
    reg_wr(ADDR_CHAN0_LO, 8'h10);
    reg_wr(ADDR_CHAN0_HI, 8'h02);
    expect_convs(0, 1, 24);
    @(posedge clock_in);
    event_in <= 2'b01;
    @(posedge clock_in);
    event_in <= 2'b00;
    expect_convs(1, 8, 8);
    chk_conv(0, 12'h215, 1'b0);
    // Dual mode, sample interval field 4, refresh off; a repeated channel 1 request is merged.
    reg_wr(ADDR_CONTROL_B, 8'h40);
    reg_wr(ADDR_CONTROL_A, 8'h0D);
    reg_wr(ADDR_TIMING_CONTROL, 8'h40);
    settle();
    chk("dual mode", 16'h0001, {15'h0000, dual_mode_out});
    chk("output 1 enable", 16'h0001, {15'h0000, drive1_en_out});
    clr();
    reg_wr(ADDR_CHAN0_LO, 8'h00);
    reg_wr(ADDR_CHAN0_HI, 8'h08);
    reg_wr(ADDR_CHAN1_LO, 8'hFF);
    reg_wr(ADDR_CHAN1_HI, 8'h0F);
    reg_wr(ADDR_CHAN1_HI, 8'h0F);
    expect_convs(2, 60, 40);
    chk_conv(0, 12'h805, 1'b0);
    chk_conv(1, 12'hFFF, 1'b1);
    chk("sample interval", 16'h0010, 16'(q_stamp[1] - q_stamp[0]));
    // Channel 1 on events in dual mode: its data writes stay silent until the event arrives.
    reg_wr(ADDR_CONTROL_B, 8'h42);
    clr();
    reg_wr(ADDR_CHAN1_LO, 8'h34);
    reg_wr(ADDR_CHAN1_HI, 8'h01);
    expect_convs(0, 1, 24);
    @(posedge clock_in);
    event_in <= 2'b10;
    @(posedge clock_in);
    event_in <= 2'b00;
    expect_convs(1, 8, 8);
    chk_conv(0, 12'h139, 1'b1);
    // Refresh field 6 with no new data: both channels reconverted every refresh interval.
    clr();
    reg_wr(ADDR_TIMING_CONTROL, 8'h46);
    expect_convs(3, 400, 8);
    chk_conv(0, 12'h805, 1'b0);
    chk_conv(1, 12'h139, 1'b1);
    chk_conv(2, 12'h805, 1'b0);
    chk("sample interval", 16'h0010, 16'(q_stamp[1] - q_stamp[0]));
    chk("refresh interval", 16'h0080, 16'(q_stamp[2] - q_stamp[0]));
    // A channel 0 request made inside a refresh, after channel 0 was refreshed, waits for channel 1, then one interval.
    clr();
    reg_wr(ADDR_CHAN0_HI, 8'h08);
    expect_convs(2, 60, 8);
    chk_conv(0, 12'h139, 1'b1);
    chk_conv(1, 12'h805, 1'b0);
    chk("request after refresh", 16'h0010, 16'(q_stamp[1] - q_stamp[0]));
    final_report();
  end
endmodule : tb_top
